// file: adcac_afe_model.sv
// Front end and converter model: samples at convert, shows the code
`timescale 1ns/10ps
module adcac_afe_model (
	input  wire logic                  clk_i,
	input  wire adcac_pkg::adcac_afe_t afe_i,
	input  wire logic [7:0]            level_i,
	output logic [11:0]                data_o
);
	import adcac_pkg::*;
	logic [11:0] code_reg = 12'h000;
	logic [1:0]  valid_reg = 2'b00;
	// Code top nibble is the channel, so results reveal the scan order
	always_ff @(posedge clk_i) begin
		if (afe_i.convert)
			code_reg <= {afe_i.channel, level_i};
		valid_reg <= {valid_reg[0], afe_i.hold};
	end
	// Past the valid window the lines show garbage, not the last code
	assign data_o = (afe_i.hold || valid_reg != 2'b00) ? code_reg : ~code_reg;
endmodule : adcac_afe_model

// file: adcac_chk.sv
// Bound checker for the acquisition control block ports
`timescale 1ns/10ps
module adcac_chk #(
	parameter int CONV_CYCLES = 225
) (
	input wire logic                  CLOCK_I,
	input wire logic                  SRST_I,
	input wire adcac_pkg::adcac_bus_t BUS_I,
	input wire logic [15:0]           RDATA_O,
	input wire adcac_pkg::adcac_afe_t AFE_O,
	input wire logic                  DMA_REQ_O,
	input wire logic                  NOT_EMPTY_O,
	input wire logic                  SCAN_CLK_O
);
	import adcac_pkg::*;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	int hold_cnt_reg;
	// Hold length in a counter; the figure is too big for a repetition
	always_ff @(posedge CLOCK_I) begin
		hold_cnt_reg <= (SRST_I || !AFE_O.hold) ? 0 : hold_cnt_reg + 1;
	end
	property p_conv_hold; AFE_O.convert |-> AFE_O.hold && SCAN_CLK_O; endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("convert without hold");
	property p_hold_len; $fell(AFE_O.hold) |-> hold_cnt_reg == CONV_CYCLES + 1; endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold length");
	property p_scan_pulse; SCAN_CLK_O |-> AFE_O.convert ##1 !SCAN_CLK_O; endproperty
	a_scan_pulse: assert property (p_scan_pulse) else $error("scan clock pulse");
	property p_mux_sel;
		AFE_O.hold && !AFE_O.differential_pair_mode |-> AFE_O.upper_channel_mux_en ==
			AFE_O.channel[3] && AFE_O.lower_channel_mux_en == !AFE_O.channel[3];
	endproperty
	a_mux_sel: assert property (p_mux_sel) else $error("mux select");
	property p_differential_pair_mode;
		AFE_O.hold && AFE_O.differential_pair_mode |->
			AFE_O.upper_channel_mux_en && AFE_O.lower_channel_mux_en;
	endproperty
	a_differential_pair_mode: assert property (p_differential_pair_mode) else $error("pair routing");
	property p_dma; DMA_REQ_O |-> NOT_EMPTY_O; endproperty
	a_dma: assert property (p_dma) else $error("dma without data");
	property p_rd_idle; !$past(BUS_I.rd) |-> RDATA_O == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_store; $fell(AFE_O.hold) |-> ##[1:2] NOT_EMPTY_O; endproperty
	a_store: assert property (p_store) else $error("result not stored");
	c_upper: cover property (AFE_O.convert && AFE_O.channel[3]);
	c_dma: cover property (DMA_REQ_O);
	c_differential_pair_mode: cover property (AFE_O.hold && AFE_O.differential_pair_mode);
endmodule : adcac_chk
bind adcac_top adcac_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .BUS_I(BUS_I), .RDATA_O(RDATA_O), .AFE_O(AFE_O),
	.DMA_REQ_O(DMA_REQ_O), .NOT_EMPTY_O(NOT_EMPTY_O), .SCAN_CLK_O(SCAN_CLK_O)
);

// file: adcac_params.svh
// Constants of the acquisition control block: offsets, fields, resets, timing
`ifndef ADCAC_PARAMS_SVH
`define ADCAC_PARAMS_SVH

// Register offsets
`define ADCAC_REG_CONFIG      5'h00
`define ADCAC_REG_STATUS      5'h01
`define ADCAC_REG_MUX_PTR     5'h02
`define ADCAC_REG_SCAN_MEM    5'h03
`define ADCAC_REG_SAMPLE_CNT  5'h04
`define ADCAC_REG_SAMPLE_DIV  5'h05
`define ADCAC_REG_SCAN_DIV    5'h06
`define ADCAC_REG_START_CONV  5'h07
`define ADCAC_REG_START_ACQ   5'h08
`define ADCAC_REG_RESULT      5'h09
`define ADCAC_REG_CLEAR       5'h0A

// Config fields
`define ADCAC_CFG_TWOS        0
`define ADCAC_CFG_DIFFERENTIAL_PAIR_MODE        1
`define ADCAC_CFG_SENSE       2
`define ADCAC_CFG_SCAN        3
`define ADCAC_CFG_INTERVAL    4
`define ADCAC_CFG_DMA_EN      5
`define ADCAC_CFG_EXT_CLK     6
`define ADCAC_CFG_RESET       16'h0000

// Status fields
`define ADCAC_ST_NOT_EMPTY    0
`define ADCAC_ST_OVERFLOW     1
`define ADCAC_ST_BUSY         2
`define ADCAC_ST_ACQ          3

// Scan memory entry fields
`define ADCAC_SM_LAST         6

// Timing: conversion allowance in ns at a 40 ns clock
`define ADCAC_CONV_TIME_NS    9000
`define ADCAC_CLK_PERIOD_NS   40
`define ADCAC_CONV_CYCLES     ((`ADCAC_CONV_TIME_NS + `ADCAC_CLK_PERIOD_NS - 1) / `ADCAC_CLK_PERIOD_NS)

// Sample/scan dividers reset values
`define ADCAC_DIV_RESET       16'h00FF
`define ADCAC_ZERO16          16'h0000

`endif

// file: adcac_pkg.sv
// Types shared by the acquisition control block
package adcac_pkg;

	// Register bus request
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} adcac_bus_t;

	// Analog front end controls
	typedef struct packed {
		logic [3:0] channel;
		logic [1:0] gain;
		logic       lower_channel_mux_en;
		logic       upper_channel_mux_en;
		logic       differential_pair_mode;
		logic       sensed_single_ended;
		logic       hold;
		logic       convert;
	} adcac_afe_t;

	// Scan memory entry
	typedef struct packed {
		logic       last;
		logic [1:0] gain;
		logic [3:0] channel;
	} adcac_scan_t;

	// Conversion sequencer states
	typedef enum logic [2:0] {
		ADCAC_IDLE = 3'b001,
		ADCAC_CONV = 3'b010,
		ADCAC_STORE = 3'b100
	} adcac_state_t;

endpackage : adcac_pkg

// file: adcac_top.sv
// Analog input acquisition control: scan memory, conversion timing, result FIFO
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "adcac_params.svh"

module adcac_top #(
	parameter int DEPTH       = 512,
	parameter int CONV_CYCLES = `ADCAC_CONV_CYCLES
) (
	input  wire logic                 CLOCK_I,
	input  wire logic                 SRST_I,
	input  wire adcac_pkg::adcac_bus_t BUS_I,
	output logic [15:0]               RDATA_O,
	input  wire logic                 EXT_CONVERT_N_I,
	input  wire logic                 EXT_START_N_I,
	input  wire logic                 BUS_CONVERT_N_I,
	input  wire logic                 BUS_START_N_I,
	input  wire logic [11:0]          ADC_DATA_I,
	output adcac_pkg::adcac_afe_t     AFE_O,
	output logic                      DMA_REQ_O,
	output logic                      NOT_EMPTY_O,
	output logic                      SCAN_CLK_O
);
	import adcac_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// Software state
	logic [15:0]       cfg_reg;
	logic [3:0]        mux_ptr_reg;
	adcac_scan_t       scan_mem_reg [16];
	logic [15:0]       sample_cnt_reg;
	logic [15:0]       sample_div_reg;
	logic [15:0]       scan_div_reg;
	logic              acq_reg;
	logic [15:0]       sample_tmr_reg;
	logic [15:0]       scan_tmr_reg;
	logic              scan_wait_reg;
	adcac_state_t      state_reg;
	logic [15:0]       conv_cnt_reg;
	logic [11:0]       fifo_reg [DEPTH];
	logic [AW-1:0]     wptr_reg;
	logic [AW-1:0]     rptr_reg;
	logic [AW:0]       count_reg;
	logic              overflow_reg;

	// Decoded strobes
	logic wr_cfg, wr_ptr, wr_mem, wr_cnt, wr_sdiv, wr_cdiv, wr_conv, wr_acq, wr_clr, rd_res;
	assign wr_cfg  = BUS_I.wr && BUS_I.addr == `ADCAC_REG_CONFIG;
	assign wr_ptr  = BUS_I.wr && BUS_I.addr == `ADCAC_REG_MUX_PTR;
	assign wr_mem  = BUS_I.wr && BUS_I.addr == `ADCAC_REG_SCAN_MEM;
	assign wr_cnt  = BUS_I.wr && BUS_I.addr == `ADCAC_REG_SAMPLE_CNT;
	assign wr_sdiv = BUS_I.wr && BUS_I.addr == `ADCAC_REG_SAMPLE_DIV;
	assign wr_cdiv = BUS_I.wr && BUS_I.addr == `ADCAC_REG_SCAN_DIV;
	assign wr_conv = BUS_I.wr && BUS_I.addr == `ADCAC_REG_START_CONV;
	assign wr_acq  = BUS_I.wr && BUS_I.addr == `ADCAC_REG_START_ACQ;
	assign wr_clr  = BUS_I.wr && BUS_I.addr == `ADCAC_REG_CLEAR;
	assign rd_res  = BUS_I.rd && BUS_I.addr == `ADCAC_REG_RESULT;

	// Falling edges of active-low triggers; connector and timing bus are merged
	logic ext_conv_edge, ext_start_edge;
	adcac_fall_det #(.N(2)) u_conv_det (
		.clk_i    (CLOCK_I),
		.srst_i   (SRST_I),
		.trig_n_i ({EXT_CONVERT_N_I, BUS_CONVERT_N_I}),
		.edge_o   (ext_conv_edge)
	);
	adcac_fall_det #(.N(2)) u_start_det (
		.clk_i    (CLOCK_I),
		.srst_i   (SRST_I),
		.trig_n_i ({EXT_START_N_I, BUS_START_N_I}),
		.edge_o   (ext_start_edge)
	);

	// Interval and scan timers; a divider of N counts N+1 cycles, so zero ticks every cycle
	logic sample_tick, scan_gate, internal_tick, conv_req, last_entry;
	assign sample_tick = acq_reg && !cfg_reg[`ADCAC_CFG_EXT_CLK]
		&& sample_tmr_reg == `ADCAC_ZERO16;
	assign last_entry  = scan_mem_reg[mux_ptr_reg].last;
	// Interval scan holds off internally timed samples until the scan interval expires
	assign scan_gate   = !(cfg_reg[`ADCAC_CFG_INTERVAL] && scan_wait_reg);
	assign internal_tick = sample_tick && scan_gate;
	assign conv_req    = state_reg == ADCAC_IDLE && (wr_conv || ext_conv_edge
		|| internal_tick);

	// Sample-interval down counter, reloads on reaching zero
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			sample_tmr_reg <= `ADCAC_ZERO16;
		end else if (!acq_reg || sample_tmr_reg == `ADCAC_ZERO16) begin
			sample_tmr_reg <= sample_div_reg;
		end else begin
			sample_tmr_reg <= sample_tmr_reg - 16'h0001;
		end
	end

	// Scan interval timer, measured start to start
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			scan_tmr_reg  <= `ADCAC_ZERO16;
			scan_wait_reg <= 1'b0;
		end else if (!acq_reg) begin
			scan_tmr_reg  <= scan_div_reg;
			scan_wait_reg <= 1'b0;
		end else begin
			if (scan_tmr_reg == `ADCAC_ZERO16) begin
				scan_tmr_reg  <= scan_div_reg;
				scan_wait_reg <= 1'b0;
			end else begin
				scan_tmr_reg <= scan_tmr_reg - 16'h0001;
			end
			if (conv_req && cfg_reg[`ADCAC_CFG_SCAN] && last_entry
				&& scan_tmr_reg != `ADCAC_ZERO16) begin
				scan_wait_reg <= 1'b1;
			end
		end
	end

	// Configuration and divider writes
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			cfg_reg        <= `ADCAC_CFG_RESET;
			sample_div_reg <= `ADCAC_DIV_RESET;
			scan_div_reg   <= `ADCAC_DIV_RESET;
		end else begin
			if (wr_cfg)  cfg_reg        <= BUS_I.wdata;
			if (wr_sdiv) sample_div_reg <= BUS_I.wdata;
			if (wr_cdiv) scan_div_reg   <= BUS_I.wdata;
		end
	end

	// Scan memory has no reset; software must fill it before scanning
	always_ff @(posedge CLOCK_I) begin
		if (wr_mem) begin
			scan_mem_reg[mux_ptr_reg] <= BUS_I.wdata[`ADCAC_SM_LAST:0];
		end
	end

	// Mux counter: loadable pointer, steps per conversion while scanning
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			mux_ptr_reg <= 4'h0;
		end else if (wr_ptr) begin
			mux_ptr_reg <= BUS_I.wdata[3:0];
		end else if (wr_mem) begin
			mux_ptr_reg <= mux_ptr_reg + 4'h1;
		end else if (conv_req && acq_reg && cfg_reg[`ADCAC_CFG_SCAN]) begin
			// Wraps at the last entry straight into the next pass
			mux_ptr_reg <= last_entry ? 4'h0 : mux_ptr_reg + 4'h1;
		end
	end

	// Acquisition run flag and sample counter
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			acq_reg        <= 1'b0;
			sample_cnt_reg <= `ADCAC_ZERO16;
		end else if (wr_cnt) begin
			sample_cnt_reg <= BUS_I.wdata;
		end else if (wr_acq || ext_start_edge) begin
			acq_reg <= sample_cnt_reg != `ADCAC_ZERO16;
		end else if (acq_reg && conv_req) begin
			sample_cnt_reg <= sample_cnt_reg - 16'h0001;
			if (sample_cnt_reg == 16'h0001) acq_reg <= 1'b0;
		end
	end

	// Conversion sequencer: hold, wait the allowance, store
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			state_reg    <= ADCAC_IDLE;
			conv_cnt_reg <= `ADCAC_ZERO16;
		end else begin
			case (state_reg)
				ADCAC_IDLE: begin
					if (conv_req) begin
						state_reg    <= ADCAC_CONV;
						conv_cnt_reg <= 16'(CONV_CYCLES - 1);
					end
				end
				ADCAC_CONV: begin
					if (conv_cnt_reg == `ADCAC_ZERO16) state_reg <= ADCAC_STORE;
					else conv_cnt_reg <= conv_cnt_reg - 16'h0001;
				end
				ADCAC_STORE: state_reg <= ADCAC_IDLE;
				default: state_reg <= ADCAC_IDLE;
			endcase
		end
	end

	// FIFO storage; a full FIFO drops the new result
	logic push, pop, full;
	assign full = count_reg == (AW+1)'(DEPTH);
	assign push = state_reg == ADCAC_STORE && !full;
	assign pop  = rd_res && count_reg != '0;
	// Next level; clear wins, a push beside a pop of the last word keeps one
	logic not_empty_next;
	assign not_empty_next = !wr_clr && (count_reg != '0 || push)
		&& !(pop && !push && count_reg == (AW+1)'(1));

	// Result storage, flip-flops indexed by the write pointer
	always_ff @(posedge CLOCK_I) begin
		if (push) fifo_reg[wptr_reg] <= ADC_DATA_I;
	end

	// Pointers and fill count; clear empties the FIFO like reset
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I || wr_clr) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end else begin
			if (push) wptr_reg <= wptr_reg + 1'b1;
			if (pop)  rptr_reg <= rptr_reg + 1'b1;
			if (push && !pop) count_reg <= count_reg + 1'b1;
			else if (pop && !push) count_reg <= count_reg - 1'b1;
		end
	end

	// Overflow flag: a new loss wins over a simultaneous clear
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			overflow_reg <= 1'b0;
		end else if (state_reg == ADCAC_STORE && full) begin
			overflow_reg <= 1'b1;
		end else if (wr_clr) begin
			overflow_reg <= 1'b0;
		end
	end

	// Oldest result: zero-extended, or in two's complement mode top bit inverted and sign-extended
	logic [11:0] head;
	logic [15:0] ext_word;
	assign head     = fifo_reg[rptr_reg];
	assign ext_word = cfg_reg[`ADCAC_CFG_TWOS]
		? {{5{~head[11]}}, head[10:0]}
		: {4'h0, head};

	// Status word; unused bits read as zero
	logic [15:0] status_word;
	always_comb begin
		status_word                      = 16'h0000;
		status_word[`ADCAC_ST_NOT_EMPTY] = count_reg != '0;
		status_word[`ADCAC_ST_OVERFLOW]  = overflow_reg;
		status_word[`ADCAC_ST_BUSY]      = state_reg != ADCAC_IDLE;
		status_word[`ADCAC_ST_ACQ]       = acq_reg;
	end

	// Read data, valid only in the cycle after the read strobe
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			RDATA_O <= 16'h0000;
		end else if (BUS_I.rd) begin
			case (BUS_I.addr)
				`ADCAC_REG_CONFIG:     RDATA_O <= cfg_reg;
				`ADCAC_REG_STATUS:     RDATA_O <= status_word;
				`ADCAC_REG_MUX_PTR:    RDATA_O <= {12'h000, mux_ptr_reg};
				`ADCAC_REG_SCAN_MEM:   RDATA_O <= {9'h000, scan_mem_reg[mux_ptr_reg]};
				`ADCAC_REG_SAMPLE_CNT: RDATA_O <= sample_cnt_reg;
				`ADCAC_REG_SAMPLE_DIV: RDATA_O <= sample_div_reg;
				`ADCAC_REG_SCAN_DIV:   RDATA_O <= scan_div_reg;
				`ADCAC_REG_RESULT:     RDATA_O <= pop ? ext_word : 16'h0000;
				default:               RDATA_O <= 16'h0000;
			endcase
		end else begin
			RDATA_O <= 16'h0000;
		end
	end

	// Front end drive; pointer moves at conversion start while held value converts
	adcac_scan_t entry;
	assign entry = scan_mem_reg[mux_ptr_reg];
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			AFE_O       <= '0;
			DMA_REQ_O   <= 1'b0;
			NOT_EMPTY_O <= 1'b0;
			SCAN_CLK_O  <= 1'b0;
		end else begin
			AFE_O.channel <= entry.channel;
			AFE_O.gain    <= entry.gain;
			AFE_O.lower_channel_mux_en <= cfg_reg[`ADCAC_CFG_DIFFERENTIAL_PAIR_MODE] || !entry.channel[3];
			AFE_O.upper_channel_mux_en <= cfg_reg[`ADCAC_CFG_DIFFERENTIAL_PAIR_MODE] || entry.channel[3];
			AFE_O.differential_pair_mode <= cfg_reg[`ADCAC_CFG_DIFFERENTIAL_PAIR_MODE];
			AFE_O.sensed_single_ended <= cfg_reg[`ADCAC_CFG_SENSE];
			AFE_O.hold    <= conv_req || state_reg == ADCAC_CONV;
			AFE_O.convert <= conv_req;
			NOT_EMPTY_O   <= not_empty_next;
			DMA_REQ_O     <= cfg_reg[`ADCAC_CFG_DMA_EN] && not_empty_next;
			SCAN_CLK_O    <= conv_req;
		end
	end

endmodule : adcac_top

// Falling-edge detector for active-low triggers merged from several sources
module adcac_fall_det #(
	parameter int N = 2
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [N-1:0] trig_n_i,
	output logic              edge_o
);
	logic low;
	logic low_d_reg;

	// Any source held low counts as asserted
	assign low    = !(&trig_n_i);
	assign edge_o = low && !low_d_reg;

	// Reset as if already low, so a pin held low through reset starts nothing
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			low_d_reg <= 1'b1;
		end else begin
			low_d_reg <= low;
		end
	end

endmodule : adcac_fall_det

// file: tb_top.sv
// Self-checking bench for the acquisition control block
`timescale 1ns/10ps
`include "adcac_params.svh"
module tb_top;
	import adcac_pkg::*;
	localparam int CONV = 4;
	logic        CLOCK_I = 1'b0;
	logic        SRST_I = 1'b1;
	adcac_bus_t  bus = '0;
	logic [3:0]  trig_n = 4'hF;
	logic [7:0]  level = 8'h00;
	logic [15:0] seed = 16'h0003;
	logic [15:0] rdata;
	logic [11:0] adc_data;
	adcac_afe_t  afe;
	logic        dma_req;
	logic        not_empty;
	logic        rd_d = 1'b0;
	logic [15:0] exp_q[$];
	logic [15:0] keep[$];
	string       name_q[$];
	int          conv_t[$];
	int          n_fail = 0;
	int          compares = 0;
	int          cyc = 0;
	int          i;
	always #20 CLOCK_I = ~CLOCK_I;
	adcac_top #(.DEPTH(8), .CONV_CYCLES(CONV)) DUT (
		.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .BUS_I(bus), .RDATA_O(rdata),
		.EXT_CONVERT_N_I(trig_n[0]), .BUS_CONVERT_N_I(trig_n[1]), .EXT_START_N_I(trig_n[2]),
		.BUS_START_N_I(trig_n[3]), .ADC_DATA_I(adc_data), .AFE_O(afe),
		.DMA_REQ_O(dma_req), .NOT_EMPTY_O(not_empty), .SCAN_CLK_O());
	adcac_afe_model u_afe (.clk_i(CLOCK_I), .afe_i(afe), .level_i(level), .data_o(adc_data));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function automatic logic [15:0] ext(input logic [11:0] d, input logic twos);
		return twos ? {{5{~d[11]}}, d[10:0]} : {4'h0, d};
	endfunction : ext
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One bus cycle; a read leaves its expected data for the monitor
	task automatic op(input bit w, input logic [4:0] a, input logic [15:0] d, input string nm);
		if (!w) begin
			exp_q.push_back(d);
			name_q.push_back(nm);
		end
		@(posedge CLOCK_I);
		bus <= '{addr: a, wdata: w ? d : 16'h0000, wr: w, rd: !w};
		@(posedge CLOCK_I);
		bus <= '0;
	endtask : op
	task automatic pulse(input int b);
		@(posedge CLOCK_I);
		trig_n[b] <= 1'b0;
		@(posedge CLOCK_I);
		trig_n[b] <= 1'b1;
	endtask : pulse
	task automatic wrap_up;
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// Monitor: read data stands one cycle after the strobe; also logs starts
	always @(posedge CLOCK_I) begin
		cyc <= cyc + 1;
		if (afe.convert)
			conv_t.push_back(cyc);
		if (rd_d)
			chk(name_q.pop_front(), rdata, exp_q.pop_front());
		rd_d <= bus.rd;
		if (cyc == 6000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge CLOCK_I);
		SRST_I <= 1'b0;
		op(0, `ADCAC_REG_STATUS, 16'h0000, "status");
		op(0, 5'h1F, 16'h0000, "unmapped");
		op(0, `ADCAC_REG_RESULT, 16'h0000, "empty_result");
		// Entry i: channel 15-i, gain i mod 4, last flag on entry 2
		op(1, `ADCAC_REG_MUX_PTR, 16'h0000, "");
		for (i = 0; i < 16; i++)
			op(1, `ADCAC_REG_SCAN_MEM, {9'h000, i == 2, 2'(i), 4'(15 - i)}, "");
		op(1, `ADCAC_REG_MUX_PTR, 16'h0005, "");
		op(0, `ADCAC_REG_SCAN_MEM, 16'h001A, "scan_entry");
		// Register write and both convert pins, both formats, pair routing on the lower half
		for (i = 0; i < 4; i++) begin
			level <= seed[7:0];
			op(1, `ADCAC_REG_CONFIG, 16'(i), "");
			op(1, `ADCAC_REG_MUX_PTR, i[1] ? 16'h000C : 16'h0005, "");
			if (i == 0)
				op(1, `ADCAC_REG_START_CONV, 16'h0000, "");
			else
				pulse(i == 2);
			repeat (CONV + 4) @(posedge CLOCK_I);
			chk("afe_sel", {10'h000, afe.gain, afe.channel}, i[1] ? 16'h0003 : 16'h001A);
			op(0, `ADCAC_REG_STATUS, 16'h0001, "not_empty");
			op(0, `ADCAC_REG_RESULT, ext({i[1] ? 4'h3 : 4'hA, seed[7:0]}, i[0]), "fmt");
			seed = lfsr(seed);
		end
		// Nine stores with no reads into a depth of eight: the last is lost
		op(1, `ADCAC_REG_CONFIG, 16'h0020, "");
		for (i = 0; i < 9; i++) begin
			level <= seed[7:0];
			keep.push_back({8'h03, seed[7:0]});
			seed = lfsr(seed);
			op(1, `ADCAC_REG_START_CONV, 16'h0000, "");
			repeat (CONV + 4) @(posedge CLOCK_I);
		end
		chk("dma_req", {15'h0000, dma_req}, 16'h0001);
		chk("not_empty", {15'h0000, not_empty}, 16'h0001);
		op(0, `ADCAC_REG_STATUS, 16'h0003, "status_full");
		for (i = 0; i < 8; i++)
			op(0, `ADCAC_REG_RESULT, keep[i], "fifo_order");
		op(0, `ADCAC_REG_STATUS, 16'h0002, "overflow");
		op(1, `ADCAC_REG_CLEAR, 16'h0000, "");
		op(0, `ADCAC_REG_STATUS, 16'h0000, "cleared");
		// A train of external convert pulses fixes spacing and count
		conv_t.delete();
		for (i = 0; i < 3; i++) begin
			pulse(0);
			repeat (CONV + 4) @(posedge CLOCK_I);
		end
		chk("train_count", 16'(conv_t.size()), 16'h0003);
		chk("train_gap", 16'(conv_t[2] - conv_t[0]), 16'(2 * (CONV + 6)));
		for (i = 0; i < 3; i++)
			op(0, `ADCAC_REG_RESULT, keep[8], "train_result");
		// Continuous then interval scans, started from the two start pins
		level <= 8'h5A;
		op(1, `ADCAC_REG_SAMPLE_DIV, 16'h0009, "");
		op(1, `ADCAC_REG_SCAN_DIV, 16'h0031, "");
		for (int k = 0; k < 2; k++) begin
			op(1, `ADCAC_REG_CONFIG, k ? 16'h0018 : 16'h0008, "");
			op(1, `ADCAC_REG_SAMPLE_CNT, 16'(5 + 2 * k), "");
			op(1, `ADCAC_REG_MUX_PTR, 16'h0000, "");
			conv_t.delete();
			pulse(2 + k);
			for (i = 0; i < 600 && conv_t.size() < 5 + 2 * k; i++)
				@(posedge CLOCK_I);
			repeat (60) @(posedge CLOCK_I);
			chk("conversions", 16'(conv_t.size()), 16'(5 + 2 * k));
			for (i = 1; i < 5; i++)
				chk("gap", 16'(conv_t[i] - conv_t[i - 1]), i == 3 && k ? 16'h001E : 16'h000A);
			for (i = 0; i < 5 + 2 * k; i++)
				op(0, `ADCAC_REG_RESULT, {4'h0, 4'(15 - i % 3), 8'h5A}, "scan_order");
		end
		chk("scan_period", 16'(conv_t[6] - conv_t[3]), 16'h0032);
		wrap_up();
	end
endmodule : tb_top
